// file: efc_pkg.sv
// Shared constants and types of the encoder feedback configuration block.
// Assumes a 32-bit Avalon-MM slave with byte addresses, one word per register.
package efc_pkg;

   // ****************************************************************
   // Register map (byte addresses)
   // ****************************************************************
   localparam logic [5:0] REG_CTRL = 6'h00;
   localparam logic [5:0] REG_LINES = 6'h04;
   localparam logic [5:0] REG_TURNS = 6'h08;
   localparam logic [5:0] REG_NUM = 6'h0c;
   localparam logic [5:0] REG_DEN = 6'h10;
   localparam logic [5:0] REG_SRC = 6'h14;
   localparam logic [5:0] REG_EFF = 6'h18;
   localparam logic [5:0] REG_REV = 6'h1c;
   localparam logic [5:0] REG_SIM = 6'h20;
   localparam logic [5:0] REG_MOTOR = 6'h24;
   localparam logic [5:0] REG_SPEED = 6'h28;
   localparam logic [5:0] REG_IRQ_ST = 6'h2c;
   localparam logic [5:0] REG_IRQ_MASK = 6'h30;

   // ****************************************************************
   // Fields, ranges and reset values
   // ****************************************************************
   localparam int unsigned CTRL_AUTO = 0;
   localparam int unsigned CTRL_WBRK = 1;
   localparam int unsigned CTRL_KIND = 2;
   localparam int unsigned CTRL_SUPPLY = 4;
   localparam int unsigned CTRL_EXC = 6;
   localparam int unsigned TURNS_COMMS = 8;
   localparam int unsigned SRC_MENU = 8;

   localparam logic [1:0] KIND_INCREMENTAL = 2'h0;
   localparam logic [1:0] KIND_SERIAL = 2'h1;
   localparam logic [1:0] KIND_RESOLVER = 2'h2;

   localparam logic [1:0] SUPPLY_5V = 2'h0;
   localparam logic [1:0] SUPPLY_8V = 2'h1;
   localparam logic [1:0] SUPPLY_15V = 2'h2;

   localparam logic [15:0] LINES_MAX = 16'hc350;
   localparam logic [4:0] TURNS_MAX = 5'h10;
   localparam logic [15:0] RATIO_MIN = 16'h0001;
   localparam logic [15:0] RATIO_MAX = 16'h7530;
   localparam logic [4:0] MENU_MAX = 5'h15;
   localparam logic [6:0] PARAM_MAX = 7'h33;
   localparam logic [15:0] LINES_TIER1 = 16'h0400;
   localparam logic [15:0] LINES_TIER2 = 16'h1000;

   localparam logic [15:0] RST_LINES = 16'h0400;
   localparam logic [15:0] RST_RATIO = 16'h2710;
   localparam logic [15:0] RST_MOTOR = 16'h0bb8;

   localparam int unsigned IRQ_W = 4;
   localparam int unsigned IRQ_REV_WRAP = 0;
   localparam int unsigned IRQ_WIRE_BREAK = 1;
   localparam int unsigned IRQ_SPEED_CLAMP = 2;
   localparam int unsigned IRQ_AUTO_LOAD = 3;

   typedef enum logic [1:0] {
      EFC_BUS_IDLE = 2'b01,
      EFC_BUS_DONE = 2'b10
   } efc_bus_state_t;

   // Byte-lane merge for Avalon writes
   function automatic logic [31:0] efc_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction

endpackage

// file: efc_sync.sv
// Two-flop synchroniser for pins arriving from the sensor cable.
// Assumes the inputs are slow levels relative to sys_clk.
`timescale 1ns/100ps
module efc_sync #(
   parameter int unsigned W = 1
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } efc_sync_state_t;

   efc_sync_state_t q;
   efc_sync_state_t next_q;

   always_comb begin
      next_q.meta = async_in;
      next_q.stable = q.meta;
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign sync_out = q.stable;
endmodule

// file: efc_ratio_scaler.sv
// Scales source increments by numerator/denominator for the simulated output.
// Assumes the denominator is never zero; zero is treated as one.
`timescale 1ns/100ps
module efc_ratio_scaler #(
   parameter int unsigned RATIO_W = 16
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic sample,
   input wire logic signed [31:0] source,
   input wire logic [RATIO_W-1:0] numerator,
   input wire logic [RATIO_W-1:0] denominator,
   output logic signed [31:0] step,
   output logic step_valid
);
   typedef struct packed {
      logic primed;
      logic signed [31:0] prev;
      logic signed [63:0] rem;
      logic [2*RATIO_W-1:0] ratio;
      logic signed [31:0] step;
      logic valid;
   } efc_scaler_state_t;

   efc_scaler_state_t q;
   efc_scaler_state_t next_q;
   logic signed [31:0] delta;
   logic signed [63:0] num_s;
   logic signed [63:0] den_s;
   logic signed [63:0] acc;
   logic signed [63:0] carry;
   logic signed [63:0] used_den;
   logic signed [63:0] quot;
   logic signed [63:0] rem;

   assign delta = source - q.prev;
   assign num_s = $signed({{(64-RATIO_W){1'b0}}, numerator});
   assign den_s = (denominator == '0) ? 64'sh1 : $signed({{(64-RATIO_W){1'b0}}, denominator});
   // A remainder left by an old ratio would skew the new one; drop it
   assign carry = ({numerator, denominator} == q.ratio) ? q.rem : 64'sh0; // R12
   assign used_den = $signed({{(64-RATIO_W){1'b0}}, q.ratio[RATIO_W-1:0]});
   assign acc = 64'(delta) * num_s + carry;
   assign quot = acc / den_s; // R2
   assign rem = acc % den_s; // R12

   always_comb begin
      next_q = q;
      next_q.valid = 1'b0;
      if (sample) begin
         next_q.prev = source;
         next_q.primed = 1'b1;
         next_q.ratio = {numerator, denominator};
         // First sample only primes; no jump from zero on start
         if (q.primed) begin
            next_q.step = 32'(quot); // R2
            next_q.rem = rem; // R12
            next_q.valid = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign step = q.step;
   assign step_valid = q.valid;

   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);

   rem_bound_a: assert property ((q.rem == 64'sh0) || ((q.rem < used_den) && (q.rem > -used_den))) // R12
      else $error("Carried remainder out of range");
   unity_ratio_a: assert property ((sample && q.primed && numerator == denominator) // R2
      |=> step == $past(delta) && step_valid)
      else $error("Unity ratio does not pass increment");
endmodule

// file: efc_encoder_feedback.sv
// Encoder feedback configuration: registers, revolution counter, simulated output.
// Assumes pins from the sensor are asynchronous; parameter and serial
// configuration inputs come from logic on sys_clk.
//
// Contract
// R1: Line count 0 to 50000 is accepted and used as resolution.
// R2: Simulated output equals source times numerator over denominator.
// R3: Denominator accepts 0.0001 to 3.0000 in units of 0.0001.
// R4: Numerator accepts 0.0001 to 3.0000 in units of 0.0001.
// R5: Source selects menu.parameter within 00.00 to 21.51 and feeds the scaler.
// R6: Revolution counter wraps to zero after two to the n revolutions.
// R7: Auto configuration with serial sensor takes turns, lines, resolution from it.
// R8: Wire-break trip never asserts while detection is disabled.
// R9: Resolver line count sets output resolution and clamps the speed limit.
// R10: Excitation selects one of two levels for 2:1 or 3:1 resolvers.
// R11: Supply selects exactly one of 5V, 8V or 15V.
// R12: Scaling carries the fractional remainder so no counts are lost. The remainder is dropped when the ratio changes.
`timescale 1ns/100ps
module efc_encoder_feedback #(
   parameter logic [15:0] SPEED_FEW_LINES = 16'h3a98,
   parameter logic [15:0] SPEED_MID_LINES = 16'h0fa0,
   parameter logic [15:0] SPEED_MANY_LINES = 16'h03e8
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic rev_tick_pin,
   input wire logic rev_dir_pin,
   input wire logic sin_loss_pin,
   input wire logic cos_loss_pin,
   input wire logic sensor_cfg_valid,
   input wire logic [4:0] sensor_turns,
   input wire logic [15:0] sensor_lines,
   input wire logic [4:0] sensor_comms_res,
   input wire logic param_strobe,
   input wire logic [31:0] param_value,
   output logic [4:0] param_menu,
   output logic [6:0] param_index,
   output logic [31:0] sim_count,
   output logic [15:0] sim_resolution,
   output logic [15:0] speed_limit,
   output logic [15:0] rev_count,
   output logic [2:0] supply_en,
   output logic excitation_high,
   output logic wire_break_trip,
   output logic irq
);
   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      efc_pkg::efc_bus_state_t bus;
      logic wait_req;
      logic [31:0] rdata;
      logic auto_config_enable;
      logic wire_break_detect_enable;
      logic [1:0] sensor_kind_select;
      logic [2:0] supply;
      logic exc_high;
      logic [15:0] encoder_line_count;
      logic [4:0] turns_bit_count;
      logic [4:0] comms_res;
      logic [15:0] sim_ratio_numerator;
      logic [15:0] sim_ratio_denominator;
      logic [4:0] menu;
      logic [6:0] index;
      logic [15:0] motor_speed;
      logic [15:0] eff_lines;
      logic [4:0] eff_turns;
      logic [4:0] eff_comms;
      logic auto_d;
      logic tick_d;
      logic [15:0] rev;
      logic [31:0] sim;
      logic [15:0] speed;
      logic clamped;
      logic wb;
      logic [efc_pkg::IRQ_W-1:0] irq_st;
      logic [efc_pkg::IRQ_W-1:0] irq_mask;
      logic irq;
   } efc_top_state_t;

   efc_top_state_t q;
   efc_top_state_t next_q;
   logic [3:0] pins;
   logic signed [31:0] sim_step;
   logic sim_step_valid;
   logic tick_rise;
   logic auto_act;
   logic [15:0] rev_mask;

   // ****************************************************************
   // Sub-blocks
   // ****************************************************************
   efc_sync #(
      .W(4)
   ) u_sync (
      .sys_clk(sys_clk),
      .reset(reset),
      .async_in({cos_loss_pin, sin_loss_pin, rev_dir_pin, rev_tick_pin}),
      .sync_out(pins)
   );

   efc_ratio_scaler #(
      .RATIO_W(16)
   ) u_scaler (
      .sys_clk(sys_clk),
      .reset(reset),
      .sample(param_strobe),
      .source(param_value),
      .numerator(q.sim_ratio_numerator),
      .denominator(q.sim_ratio_denominator),
      .step(sim_step),
      .step_valid(sim_step_valid)
   );

   function automatic logic [1:0] supply_code(input logic [2:0] oh);
      logic [1:0] c;
      c = efc_pkg::SUPPLY_5V;
      if (oh[1]) begin
         c = efc_pkg::SUPPLY_8V;
      end else if (oh[2]) begin
         c = efc_pkg::SUPPLY_15V;
      end
      return c;
   endfunction

   assign tick_rise = pins[0] && !q.tick_d;
   assign auto_act = q.auto_config_enable && (q.sensor_kind_select == efc_pkg::KIND_SERIAL)
                     && sensor_cfg_valid;
   assign rev_mask = 16'(({1'b0, 16'h0} | 17'h1) << q.eff_turns) - 16'h1;

   // ****************************************************************
   // Next-state logic
   // ****************************************************************
   always_comb begin
      logic [31:0] rd;
      logic [31:0] wv;
      logic [efc_pkg::IRQ_W-1:0] ev;
      logic [efc_pkg::IRQ_W-1:0] clr;
      logic [15:0] tier;
      logic is_res;
      rd = 32'h0;
      wv = 32'h0;
      ev = '0;
      clr = '0;
      tier = SPEED_FEW_LINES;
      is_res = (q.sensor_kind_select == efc_pkg::KIND_RESOLVER);
      next_q = q;

      case (avs_address)
         efc_pkg::REG_CTRL: begin
            rd = {25'h0, q.exc_high, supply_code(q.supply), q.sensor_kind_select,
                  q.wire_break_detect_enable, q.auto_config_enable};
         end
         efc_pkg::REG_LINES: rd = {16'h0, q.encoder_line_count};
         efc_pkg::REG_TURNS: rd = {19'h0, q.comms_res, 3'h0, q.turns_bit_count};
         efc_pkg::REG_NUM: rd = {16'h0, q.sim_ratio_numerator};
         efc_pkg::REG_DEN: rd = {16'h0, q.sim_ratio_denominator};
         efc_pkg::REG_SRC: rd = {19'h0, q.menu, 1'b0, q.index};
         efc_pkg::REG_EFF: rd = {3'h0, q.eff_comms, 3'h0, q.eff_turns, q.eff_lines};
         efc_pkg::REG_REV: rd = {16'h0, q.rev};
         efc_pkg::REG_SIM: rd = q.sim;
         efc_pkg::REG_MOTOR: rd = {16'h0, q.motor_speed};
         efc_pkg::REG_SPEED: rd = {16'h0, q.speed};
         efc_pkg::REG_IRQ_ST: rd = {28'h0, q.irq_st};
         efc_pkg::REG_IRQ_MASK: rd = {28'h0, q.irq_mask};
         default: rd = 32'h0;
      endcase
      wv = efc_pkg::efc_merge(rd, avs_writedata, avs_byteenable);

      // Bus: one wait cycle, write lands on the edge that sees waitrequest low
      next_q.wait_req = 1'b1;
      next_q.bus = efc_pkg::EFC_BUS_IDLE;
      case (q.bus)
         efc_pkg::EFC_BUS_IDLE: begin
            if (avs_read || avs_write) begin
               next_q.bus = efc_pkg::EFC_BUS_DONE;
               next_q.wait_req = 1'b0;
               next_q.rdata = avs_read ? rd : 32'h0;
            end
         end
         efc_pkg::EFC_BUS_DONE: begin
            if (avs_write) begin
               case (avs_address)
                  efc_pkg::REG_CTRL: begin
                     next_q.auto_config_enable = wv[efc_pkg::CTRL_AUTO];
                     next_q.wire_break_detect_enable = wv[efc_pkg::CTRL_WBRK];
                     if (wv[efc_pkg::CTRL_KIND +: 2] <= efc_pkg::KIND_RESOLVER) begin
                        next_q.sensor_kind_select = wv[efc_pkg::CTRL_KIND +: 2];
                     end
                     // Fourth code would mean no supply at all; keep the old one
                     case (wv[efc_pkg::CTRL_SUPPLY +: 2])
                        efc_pkg::SUPPLY_5V: next_q.supply = 3'h1; // R11
                        efc_pkg::SUPPLY_8V: next_q.supply = 3'h2; // R11
                        efc_pkg::SUPPLY_15V: next_q.supply = 3'h4; // R11
                        default: next_q.supply = q.supply;
                     endcase
                     next_q.exc_high = wv[efc_pkg::CTRL_EXC]; // R10
                  end
                  efc_pkg::REG_LINES: begin
                     if (wv[15:0] <= efc_pkg::LINES_MAX) begin
                        next_q.encoder_line_count = wv[15:0]; // R1
                     end
                  end
                  efc_pkg::REG_TURNS: begin
                     if (wv[4:0] <= efc_pkg::TURNS_MAX) begin
                        next_q.turns_bit_count = wv[4:0];
                     end
                     next_q.comms_res = wv[efc_pkg::TURNS_COMMS +: 5];
                  end
                  efc_pkg::REG_NUM: begin
                     if (wv[15:0] >= efc_pkg::RATIO_MIN && wv[15:0] <= efc_pkg::RATIO_MAX) begin
                        next_q.sim_ratio_numerator = wv[15:0]; // R4
                     end
                  end
                  efc_pkg::REG_DEN: begin
                     if (wv[15:0] >= efc_pkg::RATIO_MIN && wv[15:0] <= efc_pkg::RATIO_MAX) begin
                        next_q.sim_ratio_denominator = wv[15:0]; // R3
                     end
                  end
                  efc_pkg::REG_SRC: begin
                     if (wv[efc_pkg::SRC_MENU +: 5] <= efc_pkg::MENU_MAX
                         && wv[6:0] <= efc_pkg::PARAM_MAX) begin
                        next_q.menu = wv[efc_pkg::SRC_MENU +: 5]; // R5
                        next_q.index = wv[6:0]; // R5
                     end
                  end
                  efc_pkg::REG_MOTOR: next_q.motor_speed = wv[15:0];
                  efc_pkg::REG_IRQ_ST: begin
                     // Only written ones clear; merged lanes would echo set bits back
                     clr = avs_byteenable[0] ? avs_writedata[efc_pkg::IRQ_W-1:0] : '0;
                  end
                  efc_pkg::REG_IRQ_MASK: next_q.irq_mask = wv[efc_pkg::IRQ_W-1:0];
                  default: next_q.irq_mask = q.irq_mask;
               endcase
            end
         end
         default: next_q.bus = efc_pkg::EFC_BUS_IDLE;
      endcase

      // Effective configuration: sensor-supplied or manual
      next_q.auto_d = auto_act;
      if (auto_act) begin
         next_q.eff_lines = (sensor_lines > efc_pkg::LINES_MAX) ? efc_pkg::LINES_MAX
                            : sensor_lines; // R7
         next_q.eff_turns = (sensor_turns > efc_pkg::TURNS_MAX) ? efc_pkg::TURNS_MAX
                            : sensor_turns; // R7
         next_q.eff_comms = sensor_comms_res; // R7
      end else begin
         next_q.eff_lines = q.encoder_line_count; // R1
         next_q.eff_turns = q.turns_bit_count; // R7
         next_q.eff_comms = q.comms_res; // R7
      end
      ev[efc_pkg::IRQ_AUTO_LOAD] = auto_act && !q.auto_d;

      // Revolution counter
      next_q.tick_d = pins[0];
      if (tick_rise) begin
         if (pins[1]) begin
            next_q.rev = (q.rev + 16'h1) & rev_mask; // R6
            ev[efc_pkg::IRQ_REV_WRAP] = (q.rev == rev_mask);
         end else begin
            next_q.rev = (q.rev - 16'h1) & rev_mask; // R6
            ev[efc_pkg::IRQ_REV_WRAP] = (q.rev == 16'h0);
         end
      end else begin
         next_q.rev = q.rev & rev_mask; // R6
      end

      // Wire break only counts when detection is on and a resolver is fitted
      next_q.wb = q.wire_break_detect_enable && is_res && (pins[2] || pins[3]); // R8
      ev[efc_pkg::IRQ_WIRE_BREAK] = next_q.wb && !q.wb;

      // Speed ceiling: coarser resolver setting allows higher speed
      if (q.eff_lines > efc_pkg::LINES_TIER2) begin
         tier = SPEED_MANY_LINES;
      end else if (q.eff_lines > efc_pkg::LINES_TIER1) begin
         tier = SPEED_MID_LINES;
      end
      next_q.clamped = is_res && (tier < q.motor_speed); // R9
      next_q.speed = next_q.clamped ? tier : q.motor_speed; // R9
      ev[efc_pkg::IRQ_SPEED_CLAMP] = next_q.clamped && !q.clamped;

      // Simulated output position
      if (sim_step_valid) begin
         next_q.sim = q.sim + sim_step; // R2
      end

      // Sticky status: a new event wins over a clear in the same cycle
      next_q.irq_st = (q.irq_st & ~clr) | ev;
      next_q.irq = |(next_q.irq_st & next_q.irq_mask);
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         q <= '0;
         q.bus <= efc_pkg::EFC_BUS_IDLE;
         q.wait_req <= 1'b1;
         q.supply <= 3'h1;
         q.encoder_line_count <= efc_pkg::RST_LINES;
         q.eff_lines <= efc_pkg::RST_LINES;
         q.sim_ratio_numerator <= efc_pkg::RST_RATIO;
         q.sim_ratio_denominator <= efc_pkg::RST_RATIO;
         q.motor_speed <= efc_pkg::RST_MOTOR;
         q.speed <= efc_pkg::RST_MOTOR;
      end else begin
         q <= next_q;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign avs_readdata = q.rdata;
   assign avs_waitrequest = q.wait_req;
   assign param_menu = q.menu;
   assign param_index = q.index;
   assign sim_count = q.sim;
   assign sim_resolution = q.eff_lines;
   assign speed_limit = q.speed;
   assign rev_count = q.rev;
   assign supply_en = q.supply;
   assign excitation_high = q.exc_high;
   assign wire_break_trip = q.wb;
   assign irq = q.irq;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);

   line_refuse_a: assert property ((q.bus == efc_pkg::EFC_BUS_DONE && avs_write // R1
      && avs_address == efc_pkg::REG_LINES && avs_byteenable == 4'hf
      && avs_writedata[15:0] > efc_pkg::LINES_MAX) |=> $stable(q.encoder_line_count))
      else $error("Line count above limit was accepted");
   den_range_a: assert property (q.sim_ratio_denominator >= efc_pkg::RATIO_MIN // R3
      && q.sim_ratio_denominator <= efc_pkg::RATIO_MAX)
      else $error("Denominator out of range");
   num_range_a: assert property (q.sim_ratio_numerator >= efc_pkg::RATIO_MIN // R4
      && q.sim_ratio_numerator <= efc_pkg::RATIO_MAX)
      else $error("Numerator out of range");
   src_range_a: assert property (param_menu <= efc_pkg::MENU_MAX // R5
      && param_index <= efc_pkg::PARAM_MAX)
      else $error("Source selector out of range");
   rev_wrap_a: assert property ((tick_rise && pins[1] && q.rev == rev_mask) // R6
      |=> rev_count == 16'h0 && q.irq_st[efc_pkg::IRQ_REV_WRAP])
      else $error("Revolution counter did not wrap to zero");
   auto_load_a: assert property ((auto_act && sensor_lines <= efc_pkg::LINES_MAX) // R7
      |=> sim_resolution == $past(sensor_lines))
      else $error("Auto configuration not taken from sensor");
   manual_load_a: assert property (!q.auto_config_enable // R7
      |=> sim_resolution == $past(q.encoder_line_count))
      else $error("Manual line count not used");
   wire_quiet_a: assert property (!q.wire_break_detect_enable |=> !wire_break_trip) // R8
      else $error("Wire-break trip while detection disabled");
   speed_clamp_a: assert property ((q.sensor_kind_select == efc_pkg::KIND_RESOLVER) // R9
      |=> speed_limit <= $past(q.motor_speed))
      else $error("Resolver speed limit above motor speed");
   exc_hold_a: assert property (!(q.bus == efc_pkg::EFC_BUS_DONE && avs_write // R10
      && avs_address == efc_pkg::REG_CTRL) |=> $stable(excitation_high))
      else $error("Excitation changed without a write");
   supply_onehot_a: assert property ($onehot(supply_en)) // R11
      else $error("Supply selection not exactly one level");
endmodule

// file: efc_sensor_model.sv
// Position sensor model: revolution pulses, loss levels, serial config.
// Assumes callers run just after a rising sys_clk edge.
`timescale 1ns/100ps
module efc_sensor_model (
   input wire logic sys_clk,
   output logic rev_tick_pin,
   output logic rev_dir_pin,
   output logic sin_loss_pin,
   output logic cos_loss_pin,
   output logic sensor_cfg_valid,
   output logic [4:0] sensor_turns,
   output logic [15:0] sensor_lines,
   output logic [4:0] sensor_comms_res
);
   initial begin
      {rev_tick_pin, rev_dir_pin, sin_loss_pin, cos_loss_pin, sensor_cfg_valid} = '0;
      {sensor_turns, sensor_lines, sensor_comms_res} = '0;
   end
   // Pulse held 4 cycles so the two-flop input path cannot miss it
   task automatic turn(input logic up);
      rev_dir_pin <= up;
      rev_tick_pin <= 1'b1;
      repeat (4) @(posedge sys_clk);
      rev_tick_pin <= 1'b0;
      repeat (4) @(posedge sys_clk);
   endtask
   task automatic loss(input logic s, input logic c);
      sin_loss_pin <= s;
      cos_loss_pin <= c;
   endtask
   task automatic cfg(input logic [4:0] t, input logic [15:0] l, input logic [4:0] c);
      {sensor_turns, sensor_lines, sensor_comms_res} <= {t, l, c};
      sensor_cfg_valid <= 1'b1;
   endtask
endmodule

// file: efc_encoder_feedback_tb_top.sv
// Self-checking bench of the encoder feedback block.
// Assumes the sensor model and the design files are compiled first.
`timescale 1ns/100ps
module efc_encoder_feedback_tb_top;
   typedef struct packed {logic [5:0] a; logic [31:0] d; logic [31:0] e;} efc_row_t;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic [5:0] avs_address = '0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic param_strobe = 1'b0;
   logic [31:0] avs_writedata = '0;
   logic [31:0] param_value = '0;
   logic [3:0] avs_byteenable = 4'hf;
   logic [31:0] avs_readdata, q, sim_count;
   logic avs_waitrequest, excitation_high, wire_break_trip, irq;
   logic [15:0] sim_resolution, speed_limit, rev_count, sensor_lines;
   logic [4:0] sensor_turns, sensor_comms_res, param_menu;
   logic [6:0] param_index;
   logic [2:0] supply_en;
   logic rev_tick_pin, rev_dir_pin, sin_loss_pin, cos_loss_pin, sensor_cfg_valid;
   int errors = 0;
   int tests_run = 0;
   int cyc = 0;
   // Byte offsets; refused writes keep the old value
   efc_row_t rows [12] = '{{6'h04, 32'hc350, 32'hc350}, {6'h04, 32'hc351, 32'hc350},
      {6'h0c, 32'h0, 32'h2710}, {6'h0c, 32'h7530, 32'h7530}, {6'h10, 32'h7531, 32'h2710},
      {6'h10, 32'h1, 32'h1}, {6'h14, 32'h1533, 32'h1533}, {6'h14, 32'h1633, 32'h1533},
      {6'h08, 32'h11, 32'h0}, {6'h08, 32'h2, 32'h2}, {6'h34, 32'hffff, 32'h0},
      {6'h1c, 32'hffff, 32'h0}};
   efc_encoder_feedback efc_encoder_feedback_i (.sys_clk, .reset, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
      .rev_tick_pin, .rev_dir_pin, .sin_loss_pin, .cos_loss_pin, .sensor_cfg_valid,
      .sensor_turns, .sensor_lines, .sensor_comms_res, .param_strobe, .param_value,
      .param_menu, .param_index, .sim_count, .sim_resolution, .speed_limit, .rev_count,
      .supply_en, .excitation_high, .wire_break_trip, .irq);
   efc_sensor_model efc_sensor_model_i (.sys_clk, .rev_tick_pin, .rev_dir_pin, .sin_loss_pin,
      .cos_loss_pin, .sensor_cfg_valid, .sensor_turns, .sensor_lines, .sensor_comms_res);
   always #50 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         errors++;
         summarize();
      end
   end
   // ****
   // Tasks
   // ****
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         errors++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic rdc(input logic [5:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(q, e);
   endtask
   task automatic strobe(input logic [31:0] v);
      param_value <= v;
      param_strobe <= 1'b1;
      @(posedge sys_clk);
      param_strobe <= 1'b0;
      repeat (3) @(posedge sys_clk);
   endtask
   task automatic summarize;
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge sys_clk);
      chk({speed_limit, sim_resolution}, 32'h0bb80400);
      chk(supply_en, 32'h1);
      reset <= 1'b0;
      foreach (rows[i]) begin
         bus(1'b1, rows[i].a, rows[i].d);
         rdc(rows[i].a, rows[i].e);
      end
      chk(32'({param_menu, 1'b0, param_index}), 32'h1533);
      for (int s = 0; s < 4; s++) begin
         bus(1'b1, efc_pkg::REG_CTRL, 32'h40 | (32'(s) << 4));
         repeat (3) @(posedge sys_clk);
         chk(supply_en, (s == 3) ? 32'h4 : (32'h1 << s));
         chk(excitation_high, 32'h1);
      end
      bus(1'b1, efc_pkg::REG_CTRL, 32'h0);
      bus(1'b1, efc_pkg::REG_IRQ_MASK, 32'h1);
      repeat (3) efc_sensor_model_i.turn(1'b1);
      chk(rev_count, 32'h3);
      efc_sensor_model_i.turn(1'b1);
      chk({irq, excitation_high, rev_count}, 32'h20000);
      bus(1'b1, efc_pkg::REG_IRQ_ST, 32'h1);
      efc_sensor_model_i.turn(1'b0);
      chk(rev_count, 32'h3);
      bus(1'b1, efc_pkg::REG_IRQ_ST, 32'h1);
      repeat (2) @(posedge sys_clk);
      chk(irq, 32'h0);
      bus(1'b1, efc_pkg::REG_CTRL, 32'h8);
      efc_sensor_model_i.loss(1'b1, 1'b0);
      repeat (5) @(posedge sys_clk);
      chk(wire_break_trip, 32'h0);
      chk({speed_limit, sim_resolution}, 32'h03e8c350);
      bus(1'b1, efc_pkg::REG_CTRL, 32'ha);
      repeat (5) @(posedge sys_clk);
      chk(wire_break_trip, 32'h1);
      bus(1'b1, efc_pkg::REG_LINES, 32'h400);
      repeat (3) @(posedge sys_clk);
      chk(speed_limit, 32'h0bb8);
      efc_sensor_model_i.cfg(5'h3, 16'h07d0, 5'h5);
      bus(1'b1, efc_pkg::REG_CTRL, 32'h5);
      repeat (3) @(posedge sys_clk);
      rdc(efc_pkg::REG_EFF, 32'h050307d0);
      bus(1'b1, efc_pkg::REG_CTRL, 32'h4);
      repeat (3) @(posedge sys_clk);
      rdc(efc_pkg::REG_EFF, 32'h00020400);
      bus(1'b1, efc_pkg::REG_NUM, 32'h2710);
      bus(1'b1, efc_pkg::REG_DEN, 32'h2710);
      strobe(32'h0);
      strobe(32'ha);
      chk(sim_count, 32'ha);
      bus(1'b1, efc_pkg::REG_DEN, 32'h7530);
      // A ratio of one third only sums right if the remainder is carried
      for (int v = 20; v < 50; v += 10) strobe(32'(v));
      chk(sim_count, 32'h14);
      summarize();
   end
endmodule
